// ===== rtl/msp_regs.svh
// Constants for the multi-line serial primary
`ifndef MSP_REGS_SVH
`define MSP_REGS_SVH
`define MSP_DIV_W 16
`define MSP_DIV_MAX 16'hFFFE
`define MSP_FRAME_MIN 5'h04
`define MSP_FRAME_MAX 5'h10
`define MSP_CS_N 4
`define MSP_FMT_STD 2'h0
`define MSP_FMT_ADDR 2'h1
`define MSP_FMT_BOTH 2'h2
`define MSP_WIDTH_STD 2'h0
`define MSP_WIDTH_DUAL 2'h1
`define MSP_WIDTH_QUAD 2'h2
`define MSP_LP_MAX_HZ 10000000
`define MSP_CLK_HZ 250000000
`define MSP_LP_MIN_DIV 16'h001A
`endif

// ===== rtl/msp_pkg.sv
// Types for the multi-line serial primary
package msp_pkg;
	typedef enum {
		MSP_IDLE,
		MSP_INST,
		MSP_ADDR,
		MSP_WAIT,
		MSP_DATA,
		MSP_GAP
	} msp_state_t;
	typedef logic [1:0] msp_width_t;
endpackage

// ===== rtl/msp_core.sv
// Multi-line serial primary: clock divider, framing and phase sequencer
// Contract
// R1 - Integrator keeps the core clock no faster than the bus clock.
// R2 - Inputs from other domains pass a two-flop synchroniser automatically.
// R3 - Serial clock at most half core clock; launch and capture on opposite edges.
// R4 - Serial clock is core clock over an even divider; zero disables it.
// R5 - As secondary, core clock at most four times incoming serial clock.
// R6 - As primary the block starts every transfer and makes the serial clock.
// R7 - Each frame asserts the chosen select and shifts 4 to 16 bits, MSB first.
// R8 - Back-to-back frames keep the serial clock running between frames.
// R9 - Select is released after the last bit unless told to hold it.
// R10 - Launch edge drives transmit, capture edge samples; clock stops when idle.
// R11 - Polarity and phase give modes 0 to 3 with their idle level and edges.
// R12 - Multi-line transactions run instruction, address, wait, then data.
// R13 - Line counts per width: standard one, dual two, quad four lanes.
// R14 - Format field: 00 all single, 01 address wide, 10 both wide.
// R15 - A multi-line write has no wait phase between address and data.
// R16 - A multi-line read inserts the programmed dummy cycles before data.
// R17 - A read receives exactly the programmed frame count, then ends.
// R18 - Width select sets data lanes; instruction and address lengths programmable.
// R19 - Low-power variant: single-bit only, one select, clock at most 10 MHz.
// R20 - Secondary variant supports all modes and full duplex.
// R21 - Low-power variant finishes transfers with no processor involvement.
// R22 - Up to four select outputs, enabled by the secondary enable register.
// R23 - During wait cycles the clock toggles but no line is driven or sampled.
`timescale 1ns/1ps
`include "msp_regs.svh"
module msp_core
	import msp_pkg::*;
#(
	parameter bit LOW_POWER = 1'b0
)
(
	input wire logic clk_sys, // Core clock
	input wire logic arst_n, // Async reset, active low
	input wire logic start, // Start a transaction, one pulse
	input wire logic [15:0] serial_clock_divider, // Even divider
	input wire logic cpol, // Clock idle level
	input wire logic phase_select, // Clock phase
	input wire logic [4:0] frame_size_field, // Bits per frame
	input wire msp_pkg::msp_width_t line_width_select, // Data lanes
	input wire logic [1:0] command_format_select, // Inst/addr widths
	input wire logic [4:0] instruction_length, // Instruction bits
	input wire logic [5:0] address_length, // Address bits
	input wire logic [4:0] wait_cycles, // Dummy clocks on read
	input wire logic [15:0] receive_frame_count, // Frames on read
	input wire logic [15:0] tx_frame_count, // Frames on write
	input wire logic is_read, // Read transaction
	input wire logic back_to_back, // Keep clock between frames
	input wire logic hold_select, // Keep select after last bit
	input wire logic [3:0] secondary_enable_register, // Select enables
	input wire logic [15:0] instruction, // Instruction word
	input wire logic [31:0] address, // Address word
	input wire logic [15:0] tx_data, // Transmit frame
	input wire logic [3:0] data_in_pin, // Data lane inputs
	output logic sclk_out, // Serial clock
	output logic [3:0] cs_n_out, // Selects, active low
	output logic [3:0] data_out, // Data lane outputs
	output logic [3:0] data_oe, // Data lane enables
	output logic [15:0] rx_data, // Received frame
	output logic rx_valid, // Received frame pulse
	output logic tx_taken, // Transmit frame consumed pulse
	output logic busy // Transaction in progress
);
	import msp_pkg::*;

	function automatic logic [2:0] lanes(input msp_width_t w);
		lanes = (w == `MSP_WIDTH_QUAD) ? 3'h4 :
			(w == `MSP_WIDTH_DUAL) ? 3'h2 : 3'h1;
	endfunction

	msp_state_t state_reg, state_next;
	logic [3:0] din_s1_reg, din_s2_reg;
	logic [15:0] div_cnt_reg;
	logic sclk_reg;
	logic [3:0] cs_n_reg;
	logic [3:0] dout_reg, doe_reg;
	logic [31:0] sh_reg;
	logic [15:0] rxsh_reg, rxd_reg;
	logic rxv_reg, taken_reg, busy_reg;
	logic [5:0] bits_reg;
	logic [15:0] frames_reg;
	logic first_reg;
	logic launch_d_reg, start_d_reg;

	// Divider rounded down to even; the low-power variant floors it at the low-power limit
	wire [15:0] div_even = {serial_clock_divider[15:1], 1'b0}; // R4
	wire [15:0] div_eff = (LOW_POWER && div_even != 16'h0000 &&
		div_even < `MSP_LP_MIN_DIV) ? `MSP_LP_MIN_DIV : div_even; // R19
	wire [15:0] half = {1'b0, div_eff[15:1]}; // R3
	wire clk_on = (div_eff != 16'h0000); // R4
	wire running = busy_reg && clk_on && state_reg != MSP_GAP &&
		state_reg != MSP_IDLE;
	wire tick = running && (div_cnt_reg == half - 16'h0001);
	// Leading and trailing serial edges; sclk_reg low is the idle level
	wire lead = tick && !sclk_reg;
	wire trail = tick && sclk_reg;
	wire launch = phase_select ? lead : trail; // R10 R11
	wire capture = phase_select ? trail : lead; // R10 R11 R20
	// Lanes change one core cycle after a launch, in step with the pin clock
	wire upd = launch_d_reg || start_d_reg; // R3
	wire msp_width_t width_eff = LOW_POWER ? `MSP_WIDTH_STD :
		line_width_select; // R19
	wire [2:0] dl = lanes(width_eff); // R13 R18
	wire inst_wide = (command_format_select == `MSP_FMT_BOTH); // R14
	wire addr_wide = (command_format_select != `MSP_FMT_STD); // R14
	wire [2:0] il = inst_wide ? dl : 3'h1; // R13
	wire [2:0] al = addr_wide ? dl : 3'h1; // R13
	wire [2:0] cur_l = (state_reg == MSP_INST) ? il :
		(state_reg == MSP_ADDR) ? al : dl;
	wire [5:0] step = {3'h0, cur_l};
	wire last_bit = (bits_reg <= step);
	wire [3:0] cs_sel = LOW_POWER ? 4'h1 : secondary_enable_register; // R22
	wire [4:0] fsz = (frame_size_field < `MSP_FRAME_MIN) ? `MSP_FRAME_MIN :
		(frame_size_field > `MSP_FRAME_MAX) ? `MSP_FRAME_MAX :
		frame_size_field; // R7
	wire [15:0] nframes = is_read ? receive_frame_count : tx_frame_count;
	wire more = frames_reg > 16'h0001;
	wire [3:0] top4 = sh_reg[31:28];
	wire [3:0] out_bits = (cur_l == 3'h4) ? top4 :
		(cur_l == 3'h2) ? {2'h0, top4[3:2]} : {3'h0, top4[3]};
	wire [3:0] out_en = (cur_l == 3'h4) ? 4'hF :
		(cur_l == 3'h2) ? 4'h3 : 4'h1;
	wire [15:0] rx_shift = (dl == 3'h4) ? {rxsh_reg[11:0], din_s2_reg} :
		(dl == 3'h2) ? {rxsh_reg[13:0], din_s2_reg[1:0]} :
		{rxsh_reg[14:0], din_s2_reg[1]};
	wire data_rx = is_read && state_reg == MSP_DATA; // R17
	wire [15:0] tx_aligned = tx_data << (5'h10 - fsz);

	// Phase order: instruction, address, dummy (read only), data
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			MSP_IDLE:
				if (start && clk_on)
					state_next = (instruction_length != 5'h00) ? MSP_INST :
						(address_length != 6'h00) ? MSP_ADDR : MSP_DATA; // R6 R12
			MSP_INST:
				if (capture && last_bit)
					state_next = (address_length != 6'h00) ? MSP_ADDR :
						(is_read && wait_cycles != 5'h00) ? MSP_WAIT : MSP_DATA; // R12
			MSP_ADDR:
				if (capture && last_bit)
					state_next = (is_read && wait_cycles != 5'h00) ?
						MSP_WAIT : MSP_DATA; // R15 R16
			MSP_WAIT:
				if (capture && last_bit)
					state_next = MSP_DATA; // R16 R23
			MSP_DATA:
				if (capture && last_bit && !more)
					state_next = MSP_GAP; // R17
			MSP_GAP:
				state_next = MSP_IDLE;
			default:
				state_next = MSP_IDLE;
		endcase
	end

	// Two-flop synchroniser on the data inputs
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			din_s1_reg <= 4'h0;
			din_s2_reg <= 4'h0;
		end
		else
		begin
			din_s1_reg <= data_in_pin; // R2
			din_s2_reg <= din_s1_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			div_cnt_reg <= 16'h0000;
		else if (!running || tick)
			div_cnt_reg <= 16'h0000;
		else
			div_cnt_reg <= div_cnt_reg + 16'h0001;
	end

	// Internal clock toggles only while running, so it idles low
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			sclk_reg <= 1'b0;
		else if (!running)
			sclk_reg <= 1'b0; // R10
		else if (tick)
			sclk_reg <= ~sclk_reg; // R3
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			state_reg <= MSP_IDLE;
		else
			state_reg <= state_next;
	end

	// Shift counters and data path
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sh_reg <= 32'h0000_0000;
			bits_reg <= 6'h00;
			frames_reg <= 16'h0000;
			first_reg <= 1'b0;
			rxsh_reg <= 16'h0000;
		end
		else if (state_reg == MSP_IDLE && state_next != MSP_IDLE)
		begin
			frames_reg <= nframes;
			first_reg <= 1'b1;
			if (state_next == MSP_INST)
			begin
				sh_reg <= {instruction << (5'h10 - instruction_length),
					16'h0000};
				bits_reg <= {1'b0, instruction_length};
			end
			else if (state_next == MSP_ADDR)
			begin
				sh_reg <= address << (6'h20 - address_length);
				bits_reg <= address_length;
			end
			else
			begin
				sh_reg <= {tx_aligned, 16'h0000};
				bits_reg <= {1'b0, fsz}; // R7
			end
		end
		else if (capture)
		begin
			first_reg <= 1'b0;
			if (data_rx)
				rxsh_reg <= rx_shift; // R10
			if (!last_bit)
				bits_reg <= bits_reg - step;
			else if (state_next == MSP_ADDR)
			begin
				sh_reg <= address << (6'h20 - address_length);
				bits_reg <= address_length;
				first_reg <= 1'b1;
			end
			else if (state_next == MSP_WAIT)
			begin
				bits_reg <= {1'b0, wait_cycles} * {3'h0, dl};
				first_reg <= 1'b1;
			end
			else if (state_next == MSP_DATA)
			begin
				if (state_reg == MSP_DATA)
					frames_reg <= frames_reg - 16'h0001; // R8
				sh_reg <= {tx_aligned, 16'h0000};
				bits_reg <= {1'b0, fsz};
				first_reg <= 1'b1;
			end
		end
		else if (launch && !first_reg && state_reg != MSP_WAIT)
			sh_reg <= sh_reg << cur_l; // R10
		else if (launch)
			first_reg <= 1'b0;
	end

	// Pin drivers: mode polarity, lane enables, selects
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_out <= 1'b0;
			cs_n_out <= 4'hF;
			dout_reg <= 4'h0;
			doe_reg <= 4'h0;
			launch_d_reg <= 1'b0;
			start_d_reg <= 1'b0;
		end
		else
		begin
			sclk_out <= sclk_reg ^ cpol; // R11
			launch_d_reg <= launch;
			start_d_reg <= state_reg == MSP_IDLE && state_next != MSP_IDLE;
			// Release one cycle after the gap so the last capture edge is clean
			if (state_reg == MSP_IDLE && state_next != MSP_IDLE)
				cs_n_out <= ~cs_sel; // R7 R22
			else if (state_reg == MSP_IDLE && busy_reg && !hold_select)
				cs_n_out <= 4'hF; // R9
			if (state_reg == MSP_IDLE)
				doe_reg <= 4'h0;
			else if (upd && (state_reg == MSP_WAIT || data_rx ||
				state_reg == MSP_GAP))
				doe_reg <= 4'h0; // R23
			else if (upd)
				doe_reg <= out_en; // R13
			if (upd)
				dout_reg <= out_bits;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rxd_reg <= 16'h0000;
			rxv_reg <= 1'b0;
			taken_reg <= 1'b0;
			busy_reg <= 1'b0;
		end
		else
		begin
			rxv_reg <= data_rx && capture && last_bit; // R17
			taken_reg <= !is_read && state_reg != MSP_DATA &&
				state_next == MSP_DATA || !is_read && state_reg == MSP_DATA &&
				capture && last_bit && more;
			if (data_rx && capture && last_bit)
				rxd_reg <= rx_shift >> (5'h10 - fsz);
			busy_reg <= (state_next != MSP_IDLE) ||
				(state_reg == MSP_GAP); // R6 R21
		end
	end

	assign data_out = dout_reg;
	assign data_oe = doe_reg;
	assign rx_data = rxd_reg;
	assign rx_valid = rxv_reg;
	assign tx_taken = taken_reg;
	assign busy = busy_reg;

	a_idle_clock_level: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!busy_reg && !$past(busy_reg) |=> sclk_out == $past(cpol)) // R10
		else $error("serial clock not at idle level");
	a_zero_div_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
		div_eff == 16'h0000 |-> !running) // R4
		else $error("clock runs with zero divider");
	a_half_rate_min: assert property (@(posedge clk_sys) disable iff (!arst_n)
		running |-> div_eff >= 16'h0002) // R3
		else $error("serial clock above half core rate");
	a_wait_no_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state_reg == MSP_WAIT && capture |=> doe_reg == 4'h0) // R23
		else $error("lines driven during wait");
	a_write_no_wait: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!is_read && state_reg == MSP_ADDR |=> state_reg != MSP_WAIT) // R15
		else $error("wait phase in write");
	a_release_select: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state_reg == MSP_GAP && !hold_select |-> ##2 cs_n_out == 4'hF) // R9
		else $error("select not released");
	a_lp_single_lane: assert property (@(posedge clk_sys) disable iff (!arst_n)
		LOW_POWER |-> doe_reg[3:1] == 3'h0) // R19
		else $error("low-power drives extra lanes");
	a_select_on_start: assert property (@(posedge clk_sys) disable iff (!arst_n)
		state_reg == MSP_IDLE && state_next == MSP_INST |=>
		cs_n_out == ~cs_sel) // R22
		else $error("select not asserted");
endmodule

// ===== bench/msp_flash_model.sv
// Behavioural serial secondary that answers on data line one
`timescale 1ns/1ps
module msp_flash_model #(
	parameter logic [15:0] PAT = 16'hC3A5
)
(
	input wire logic sclk, // Serial clock
	input wire logic sel_n, // Low while any select is low
	input wire logic cpol, // Clock idle level
	input wire logic pha, // Clock phase
	output logic miso // Reply line
);
	int cap = 0;
	initial miso = 1'b0;
	always @(negedge sel_n)
	begin
		cap = 0;
		miso = PAT[15];
	end
	// Released line shows the inverse, never a stale bit
	always @(posedge sel_n)
		miso = ~miso;
	// Change on the launch edge only, count capture edges
	always @(sclk)
		if (sel_n === 1'b0)
		begin
			if (sclk !== (cpol ^ pha))
				cap++;
			else
				miso = PAT[15 - cap % 16];
		end
endmodule

// ===== bench/tb.sv
// Self-checking bench for the multi-line serial primary
`timescale 1ns/1ps
module tb;
	import msp_pkg::*;
	localparam logic [15:0] PAT = 16'hC3A5;
	logic clk_sys = 0, arst_n = 0, start = 0, cpol = 0, pha = 0;
	logic is_read = 0, b2b = 1, hold = 0, sclk, rxv, txt, busy, miso;
	logic [15:0] div = 16'h0004, rfc = 0, tfc = 0, instr = 0, txd = 0;
	logic [4:0] fs = 5'h08, il = 5'h08, wc = 5'h00;
	logic [5:0] al = 6'h08;
	logic [31:0] addr = 0;
	msp_width_t lw = 2'h0;
	logic [1:0] fmt = 2'h0;
	logic [3:0] sec_en = 4'h1, cs_n, dout, doe;
	logic [15:0] rxd;
	int err_count = 0, tests_run = 0, seed = 90, caps, rxn, txn, m, k;
	logic exp_q[$];
	logic [15:0] rx_q[$];
	realtime last;
	// One core clock also serves as bus clock
	always #2 clk_sys = ~clk_sys;
	msp_core msp_core_i (.clk_sys, .arst_n, .start,
		.serial_clock_divider(div), .cpol, .phase_select(pha),
		.frame_size_field(fs), .line_width_select(lw),
		.command_format_select(fmt), .instruction_length(il),
		.address_length(al), .wait_cycles(wc),
		.receive_frame_count(rfc), .tx_frame_count(tfc), .is_read,
		.back_to_back(b2b), .hold_select(hold),
		.secondary_enable_register(sec_en), .instruction(instr),
		.address(addr), .tx_data(txd), .data_in_pin({2'b11, miso, 1'b1}),
		.sclk_out(sclk), .cs_n_out(cs_n), .data_out(dout),
		.data_oe(doe), .rx_data(rxd), .rx_valid(rxv), .tx_taken(txt),
		.busy);
	msp_flash_model #(.PAT(PAT)) msp_flash_model_i (.sclk,
		.sel_n(&cs_n), .cpol, .pha, .miso);
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	task automatic stop_test();
		$display("Mismatches %0d, checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(sclk)
		if (busy === 1'b1 && sclk === ~(cpol ^ pha))
		begin
			caps++;
			if (last > 0)
				chk($realtime - last == div * 4.0, "clock rate");
			last = $realtime;
			for (m = 3; m >= 0; m--)
				if (doe[m] === 1'b1 && exp_q.size() > 0)
					chk(dout[m] === exp_q.pop_front(), "wire bit");
		end
	always @(posedge clk_sys)
	begin
		rxn += (rxv === 1'b1);
		txn += (txt === 1'b1);
		if (rxv === 1'b1 && rx_q.size() > 0)
			chk(rxd === rx_q.pop_front(), "receive word");
	end
	task automatic run(input int frames);
		int n, ln, ec;
		instr = $random(seed);
		addr = $random(seed);
		txd = $random(seed);
		caps = 0;
		rxn = 0;
		txn = 0;
		last = 0;
		ln = (lw == 2'h0) ? 1 : (lw == 2'h1) ? 2 : 4;
		ec = il / (fmt == 2'h2 ? ln : 1) + al / (fmt == 2'h0 ? 1 : ln);
		ec += is_read ? wc + frames * fs : frames * fs / ln;
		for (n = il - 1; n >= 0; n--)
			exp_q.push_back(instr[n]);
		for (n = al - 1; n >= 0; n--)
			exp_q.push_back(addr[n]);
		rfc = frames;
		tfc = frames;
		for (n = 0; n < frames * fs; n++)
			if (is_read)
				rx_q.push_back(PAT);
			else
				exp_q.push_back(txd[fs - 1 - n % fs]);
		if (is_read)
			rx_q = rx_q[0:frames - 1];
		@(posedge clk_sys);
		#1 start = 1;
		@(posedge clk_sys);
		#1 start = 0;
		chk(busy === 1'b1 && cs_n === ~sec_en, "select");
		for (n = 0; busy === 1'b1 && n < 5000; n++)
			@(posedge clk_sys) #1;
		#1;
		if (n >= 5000)
		begin
			chk(1'b0, "timeout");
			stop_test();
		end
		chk(exp_q.size() == 0 && rx_q.size() == 0, "units");
		chk(caps == ec, "clock count");
		chk(is_read ? rxn == frames : txn == frames, "frames");
		chk(sclk === cpol, "idle level");
		chk(cs_n === (hold ? ~sec_en : 4'hF), "select end");
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		#1 arst_n = 1;
		chk(cs_n === 4'hF && busy === 1'b0 && sclk === 1'b0, "reset");
		div = 16'h0000;
		@(posedge clk_sys);
		#1 start = 1;
		@(posedge clk_sys);
		#1 start = 0;
		repeat (4) @(posedge clk_sys);
		chk(busy === 1'b0 && cs_n === 4'hF, "divider zero");
		for (k = 0; k < 4; k++)
		begin
			{cpol, pha} = k[1:0];
			lw = (k == 3) ? 2'h2 : k[1:0];
			fmt = (k == 3) ? 2'h1 : k[1:0];
			fs = 5'h04 + 5'h04 * k[4:0];
			div = 16'h0002 + 16'h0002 * k[15:0];
			sec_en = 4'h1 << k;
			b2b = $random(seed);
			run(3);
		end
		{cpol, pha} = 2'b11;
		{lw, fmt, fs, wc, div, is_read} = {4'h0, 5'h10, 5'h10, 16'h0008, 1'b1};
		run(2);
		{is_read, hold, fs} = {1'b0, 1'b1, 5'h08};
		run(1);
		stop_test();
	end
endmodule
